// ==== logic/pcd_pkg.sv ====
// constants and types for the pulse-count dimming controller
package pcd_pkg;
    localparam int unsigned CLK_MHZ         = 200;
    localparam int unsigned PROG_LOW_MIN_NS = 200;
    localparam int unsigned PROG_HIGH_MIN_NS = 200;
    localparam int unsigned PROG_LOW_MAX_US = 100;
    localparam int unsigned SHUTDOWN_LOW_US = 1500;
    localparam int unsigned PUMP_STEP_US    = 120;
    localparam int unsigned PROG_LOW_MIN_CYC  = (PROG_LOW_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned PROG_HIGH_MIN_CYC = (PROG_HIGH_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned PROG_LOW_MAX_CYC  = PROG_LOW_MAX_US * CLK_MHZ;
    localparam int unsigned SHUTDOWN_LOW_CYC  = SHUTDOWN_LOW_US * CLK_MHZ;
    localparam int unsigned PUMP_STEP_CYC     = PUMP_STEP_US * CLK_MHZ;
    localparam int unsigned CNT_W   = 20;
    localparam int unsigned LEVELS  = 31;
    localparam logic [4:0]  LEVEL_ZERO  = 5'h1F;
    localparam logic [4:0]  COUNT_RESET = 5'h00;
    localparam logic [1:0]  PUMP_1X    = 2'h0;
    localparam logic [1:0]  PUMP_1P33X = 2'h1;
    localparam logic [1:0]  PUMP_1P5X  = 2'h2;
    localparam logic [1:0]  PUMP_2X    = 2'h3;

    typedef enum logic [2:0] {
        PCD_OFF     = 3'h1,
        PCD_ON      = 3'h2,
        PCD_THERMAL = 3'h4
    } pcd_mode_t;
endpackage

// ==== logic/pcd_sync.sv ====
// two-flop synchroniser for asynchronous pin levels
module pcd_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } pcd_sync_st_t;

    pcd_sync_st_t st;
    pcd_sync_st_t next_st;

    always_comb begin
        next_st    = st;
        next_st.s1 = d;
        next_st.s2 = st.s1;
        if (!rstn) begin
            next_st = '0;
        end
    end

    always_ff @(posedge clk) begin
        st <= next_st;
    end

    assign q = st.s2;
endmodule

// ==== logic/pcd_dimming_ctrl.sv ====
// enable, pulse-count dimming, pump-mode and protection control
// Overview of operation
// [RL1] each valid rising edge lowers current one step
// [RL2] count wraps: 31 gives zero, 32 full
// [RL3] current code is 31 minus pulse count
// [RL4] count accumulates pulses since enable
// [RL5] host keeps phases 200 ns, low under 100 us
// [RL6] too-short low phases are filtered out
// [RL7] overlong low phase registers no step
// [RL8] low for 1.5 ms forces shutdown
// [RL9] host may burst pulses to reach zero
// [RL10] open channels excluded from regulation and pump
// [RL11] all channels open selects unity pump
// [RL12] overvoltage resets pump mode selection
// [RL13] overtemperature shuts down until flag clears
// [RL14] first high after shutdown enables full scale
// [RL15] regulation loss steps pump up after 120 us
// [RL16] shutdown turns all channels off, high-z
// [RL17] leaving the 1.5 ms shutdown clears the pulse count; thermal shutdown keeps it
module pcd_dimming_ctrl (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       enable_dim_input,
    input  wire logic [2:0] led_open,
    input  wire logic [2:0] led_low_headroom,
    input  wire logic       pump_output_overvoltage,
    input  wire logic       over_temperature,
    output logic            device_enabled,
    output logic [4:0]      current_code,
    output logic [4:0]      pulse_count,
    output logic [1:0]      pump_mode,
    output logic [2:0]      led_channel_enable,
    output logic [2:0]      led_channel_hiz
);
    typedef struct packed {
        pcd_pkg::pcd_mode_t         mode;
        logic                       pin_d;
        logic [pcd_pkg::CNT_W-1:0]  low_cnt;
        logic [pcd_pkg::CNT_W-1:0]  high_cnt;
        logic                       low_valid;
        logic                       low_long;
        logic [4:0]                 count;
        logic [1:0]                 pump;
        logic [pcd_pkg::CNT_W-1:0]  pump_cnt;
        logic [4:0]                 code;
        logic [2:0]                 ch_en;
    } pcd_st_t;

    pcd_st_t    st;
    pcd_st_t    next_st;
    logic [8:0] sync_out;
    logic       pin;
    logic [2:0] open_s;
    logic [2:0] headroom_s;
    logic       ovp_s;
    logic       otp_s;
    logic       over_temperature_s;

    // all pins are asynchronous to clk, so every one is synchronised
    pcd_sync #(
        .W (9)
    ) u_sync (
        .clk  (clk),
        .rstn (rstn),
        .d    ({enable_dim_input, led_open, led_low_headroom,
                pump_output_overvoltage, over_temperature}),
        .q    (sync_out)
    );

    assign pin                = sync_out[8];
    assign open_s             = sync_out[7:5];
    assign headroom_s         = sync_out[4:2];
    assign ovp_s              = sync_out[1];
    assign otp_s              = sync_out[0];
    // one synchroniser for all pins keeps their latencies equal
    assign over_temperature_s = otp_s;

    function automatic logic [pcd_pkg::CNT_W-1:0] sat_inc(
        input logic [pcd_pkg::CNT_W-1:0] v
    );
        return (&v) ? v : v + 1'b1;
    endfunction

    always_comb begin
        next_st          = st;
        next_st.pin_d    = pin;
        next_st.code     = 5'(pcd_pkg::LEVELS) - st.count; // [RL3]
        next_st.ch_en    = 3'h0;
        unique case (st.mode)
            pcd_pkg::PCD_OFF: begin
                next_st.count    = pcd_pkg::COUNT_RESET; // [RL17]
                next_st.pump     = pcd_pkg::PUMP_1X;
                next_st.pump_cnt = '0;
                next_st.code     = 5'h00;
                if (pin && !over_temperature_s) begin
                    next_st.mode      = pcd_pkg::PCD_ON; // [RL14]
                    next_st.high_cnt  = '0;
                    next_st.low_valid = 1'b0;
                end
            end
            pcd_pkg::PCD_ON: begin
                next_st.ch_en = ~open_s; // [RL10]
                if (pin) begin
                    next_st.low_cnt  = '0;
                    next_st.high_cnt = sat_inc(st.high_cnt);
                    // low phase judged at the rising edge
                    if (!st.pin_d) begin
                        next_st.high_cnt = '0;
                        // too short filtered, too long ignored
                        if (st.low_valid && !st.low_long) begin // [RL6] [RL7]
                            next_st.count = st.count + 5'h01; // [RL1] [RL2] [RL4]
                        end
                    end
                end else begin
                    next_st.low_cnt = sat_inc(st.low_cnt);
                    if (st.pin_d) begin
                        // the first low cycle counts, so exactly 200 ns is accepted
                        next_st.low_cnt   = pcd_pkg::CNT_W'(1);
                        // a high phase under the minimum discards the pulse
                        next_st.low_valid = 1'b0;
                        next_st.low_long  = st.high_cnt < pcd_pkg::CNT_W'(
                                            pcd_pkg::PROG_HIGH_MIN_CYC - 1);
                    end
                    if (st.low_cnt >= pcd_pkg::CNT_W'(pcd_pkg::PROG_LOW_MIN_CYC - 1)) begin
                        next_st.low_valid = 1'b1;
                    end
                    if (st.low_cnt >= pcd_pkg::CNT_W'(pcd_pkg::PROG_LOW_MAX_CYC)) begin
                        next_st.low_long = 1'b1;
                    end
                    if (st.low_cnt >= pcd_pkg::CNT_W'(pcd_pkg::SHUTDOWN_LOW_CYC - 1)) begin
                        next_st.mode = pcd_pkg::PCD_OFF; // [RL8]
                    end
                end
                if (st.count == 5'(pcd_pkg::LEVELS) && pin && !st.pin_d
                        && st.low_valid && !st.low_long) begin
                    next_st.count = pcd_pkg::COUNT_RESET; // [RL2]
                end
                // pump selection over connected channels only
                if (&open_s) begin
                    next_st.pump     = pcd_pkg::PUMP_1X; // [RL11]
                    next_st.pump_cnt = '0;
                end else if (|(headroom_s & ~open_s)) begin // [RL10]
                    if (st.pump != pcd_pkg::PUMP_2X) begin
                        next_st.pump_cnt = sat_inc(st.pump_cnt);
                        if (st.pump_cnt >= pcd_pkg::CNT_W'(pcd_pkg::PUMP_STEP_CYC - 1)) begin
                            next_st.pump     = st.pump + 2'h1; // [RL15]
                            next_st.pump_cnt = '0;
                        end
                    end
                end else begin
                    next_st.pump_cnt = '0;
                end
                if (ovp_s) begin
                    next_st.pump     = pcd_pkg::PUMP_1X; // [RL12]
                    next_st.pump_cnt = '0;
                end
                if (over_temperature_s) begin
                    next_st.mode = pcd_pkg::PCD_THERMAL; // [RL13]
                end
                if (next_st.mode != pcd_pkg::PCD_ON) begin
                    next_st.ch_en = 3'h0; // [RL16]
                    next_st.code  = 5'h00;
                end
            end
            pcd_pkg::PCD_THERMAL: begin
                next_st.pump     = pcd_pkg::PUMP_1X;
                next_st.pump_cnt = '0;
                next_st.code     = 5'h00; // [RL16]
                // hysteresis lives in the sensor; its flag falls 20 degrees lower
                if (!over_temperature_s) begin
                    next_st.mode = pcd_pkg::PCD_ON; // [RL13]
                end
                if (st.low_cnt >= pcd_pkg::CNT_W'(pcd_pkg::SHUTDOWN_LOW_CYC - 1)) begin
                    next_st.mode = pcd_pkg::PCD_OFF; // [RL8]
                end
                next_st.low_cnt = pin ? '0 : sat_inc(st.low_cnt);
            end
            default: begin
                next_st.mode = pcd_pkg::PCD_OFF;
            end
        endcase
        if (!rstn) begin
            next_st      = '0;
            next_st.mode = pcd_pkg::PCD_OFF;
        end
    end

    always_ff @(posedge clk) begin
        st <= next_st;
    end

    assign device_enabled     = (st.mode == pcd_pkg::PCD_ON);
    assign current_code       = st.code;
    assign pulse_count        = st.count;
    assign pump_mode          = st.pump;
    assign led_channel_enable = st.ch_en;
    assign led_channel_hiz    = ~st.ch_en;
endmodule

// ==== bench/pcd_dimming_ctrl_properties.sv ====
// port assertions for the dimming controller
module pcd_dimming_ctrl_properties (
    input wire logic       clk,
    input wire logic       rstn,
    input wire logic       enable_dim_input,
    input wire logic [2:0] led_open,
    input wire logic [2:0] led_low_headroom,
    input wire logic       pump_output_overvoltage,
    input wire logic       over_temperature,
    input wire logic       device_enabled,
    input wire logic [4:0] current_code,
    input wire logic [4:0] pulse_count,
    input wire logic [1:0] pump_mode,
    input wire logic [2:0] led_channel_enable,
    input wire logic [2:0] led_channel_hiz
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // cycles since the count last moved; saturates so long idles stay legal
    logic [7:0] gap;
    logic [4:0] last;
    always_ff @(posedge clk) begin
        last <= pulse_count;
        if (!rstn || pulse_count != last) gap <= 8'h00;
        else if (gap != 8'hFF) gap <= gap + 8'h01;
    end
    sequence s_pin_high;
        (enable_dim_input && !over_temperature)[*4];
    endsequence
    a_off_all_dark: assert property (
        !device_enabled |-> led_channel_enable == 3'h0 && led_channel_hiz == 3'h7
        && current_code == 5'h00) else $error("off state not dark");
    a_code_tracks_count: assert property (
        device_enabled && $past(device_enabled) |-> current_code == 5'h1F - $past(pulse_count))
        else $error("code does not track count");
    a_count_step_one: assert property (
        device_enabled && $past(device_enabled) && $changed(pulse_count)
        |-> pulse_count == $past(pulse_count) + 5'h01) else $error("count step wrong");
    a_step_gap_min: assert property (
        device_enabled && $past(device_enabled) && $changed(pulse_count) |-> gap >= 8'h46)
        else $error("steps too close");
    a_wake_on_high: assert property (
        s_pin_high |-> device_enabled) else $error("no wake on high");
    a_open_unity: assert property (
        (led_open == 3'h7)[*4] |-> pump_mode == pcd_pkg::PUMP_1X) else $error("open not 1x");
    a_ovp_unity: assert property (
        $rose(pump_output_overvoltage) |-> ##[2:4] pump_mode == pcd_pkg::PUMP_1X)
        else $error("overvoltage not 1x");
    a_hot_shutdown: assert property (
        over_temperature[*4] |-> !device_enabled) else $error("hot but enabled");
    a_pump_one_step: assert property (
        $changed(pump_mode) && pump_mode != pcd_pkg::PUMP_1X
        |-> pump_mode == $past(pump_mode) + 2'h1) else $error("pump skipped a ratio");
endmodule
bind pcd_dimming_ctrl pcd_dimming_ctrl_properties u_props (.*);

// ==== bench/pcd_host_model.sv ====
// host driving the single enable and dimming line
module pcd_host_model (
    input wire logic clk,
    output logic     enable_dim_input
);
    timeunit 1ns;
    timeprecision 100ps;
    initial enable_dim_input = 1'b0;
    // level seen for exactly n rising edges
    task automatic hold(input logic v, input int n);
        @(posedge clk);
        #1 enable_dim_input = v;
        repeat (n - 1) @(posedge clk);
    endtask
    task automatic pulse(input int lo, input int hi);
        hold(1'b0, lo);
        hold(1'b1, hi);
    endtask
endmodule

// ==== bench/pcd_dimming_ctrl_tb_top.sv ====
// self-checking bench for the dimming controller
module pcd_dimming_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic       clk = 1'b0;
    logic       rstn = 1'b0;
    logic       pin;
    logic [2:0] open_ch = 3'h0;
    logic [2:0] headroom = 3'h0;
    logic       ovp = 1'b0;
    logic       hot = 1'b0;
    logic       dev_on;
    logic [4:0] code;
    logic [4:0] count;
    logic [1:0] pump;
    logic [2:0] ch_en;
    logic [2:0] ch_hiz;
    int         n_errors = 0;
    int         n_checks = 0;
    always #2.5 clk = ~clk;
    pcd_host_model host (.clk(clk), .enable_dim_input(pin));
    pcd_dimming_ctrl uut (.clk(clk), .rstn(rstn), .enable_dim_input(pin), .led_open(open_ch),
        .led_low_headroom(headroom), .pump_output_overvoltage(ovp), .over_temperature(hot),
        .device_enabled(dev_on), .current_code(code), .pulse_count(count), .pump_mode(pump),
        .led_channel_enable(ch_en), .led_channel_hiz(ch_hiz));
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d, mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic t_wake;
        host.hold(1'b1, 60);
        #2 chk("enabled", 1, dev_on);
        chk("count", 0, count);
        chk("code", 31, code);
        chk("hiz", 0, ch_hiz);
        $display("wake done");
    endtask
    task automatic t_sweep;
        for (int i = 1; i <= 32; i++) begin
            host.pulse(40, 40);
            #2 chk("count", i % 32, count);
            chk("code", 31 - i % 32, code);
        end
        $display("sweep done");
    endtask
    task automatic t_short;
        host.pulse(39, 40);
        #2 chk("short low", 0, count);
        host.pulse(20100, 40);
        #2 chk("long low", 0, count);
        chk("long low on", 1, dev_on);
        host.pulse(40, 40);
        #2 chk("after long", 1, count);
        $display("filter done");
    endtask
    task automatic t_hot;
        @(posedge clk);
        #1 hot = 1'b1;
        repeat (8) @(posedge clk);
        #1 chk("hot", 0, dev_on);
        chk("hot hiz", 7, ch_hiz);
        chk("hot pump", 0, pump);
        hot = 1'b0;
        repeat (8) @(posedge clk);
        #1 chk("resume", 1, dev_on);
        chk("resume code", 30, code);
        $display("thermal done");
    endtask
    task automatic t_pump(input logic by_open);
        @(posedge clk);
        #1 headroom = 3'h4;
        repeat (23990) @(posedge clk);
        #1 chk("pump early", 0, pump);
        repeat (30) @(posedge clk);
        #1 chk("pump up", 1, pump);
        if (by_open) open_ch = 3'h7;
        else ovp = 1'b1;
        repeat (8) @(posedge clk);
        #1 chk("pump reset", 0, pump);
        chk("channels", by_open ? 0 : 7, ch_en);
        open_ch = 3'h0;
        ovp = 1'b0;
        headroom = 3'h0;
        $display("pump done");
    endtask
    initial begin
        repeat (20) @(posedge clk);
        #1 rstn = 1'b1;
        t_wake;
        t_sweep;
        t_short;
        t_hot;
        t_pump(1'b1);
        t_pump(1'b0);
        wrap_up;
    end
    initial begin
        repeat (100000) @(posedge clk);
        n_errors++;
        wrap_up;
    end
endmodule
